// ---- oled_if_pkg.sv ----
// constants, modes and pin layout shared by both ends of the display host port
// assumes one system clock of CLK_NS on both ends
`default_nettype none

package oled_if_pkg;

    typedef enum logic [1:0] {M_SPI4, M_SPI3, M_80, M_68} mode_t;

    // synchronised pin bundle seen by the device end
    typedef struct packed {
        logic       cs_n;
        logic       dc;
        logic       strobe;
        logic       dir;
        logic [7:0] bus;
        logic       bs_lo;
        logic       bs_hi;
        logic       rst_n;
    } pin_s_t;

    localparam int         CLK_NS       = 8;
    localparam int         CNT_W        = 5;
    localparam int         BIT_W        = 4;
    localparam int         SCK_BIT      = 0;
    localparam int         SDI_BIT      = 1;
    localparam logic [7:0] CONTRAST_RST = 8'h7F;
    localparam logic [6:0] START_RST    = 7'h00;
    localparam logic [7:0] BUS_IDLE     = 8'hFF;
    localparam logic [3:0] SPI4_BITS    = 4'h8;
    localparam logic [3:0] SPI3_BITS    = 4'h9;
    localparam int         FRAME_HALF_DEF = 625000;

    // host-side phase times, least times rounded up to whole cycles
    localparam int SETUP_NS  = 16;
    localparam int ACT_NS    = 160;
    localparam int HOLD_NS   = 40;
    localparam int GAP_NS    = 80;
    localparam int HALF_NS   = 80;
    localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] ACT_CYC   = CNT_W'((ACT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] GAP_CYC   = CNT_W'((GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] HALF_CYC  = CNT_W'((HALF_NS + CLK_NS - 1) / CLK_NS);

    function automatic mode_t decode_mode(input logic lo, input logic hi);
        mode_t m;
        unique case ({hi, lo})
            2'h0: m = M_SPI4;
            2'h1: m = M_SPI3;
            2'h2: m = M_80;
            2'h3: m = M_68;
        endcase
        return m;
    endfunction

endpackage

`default_nettype wire

// ---- oled_if.sv ----
// pin bundle between host controller and display module
// the shared data bus resolves from the two enables, idle level high
`default_nettype none

interface oled_if;
    logic       bus_select_lo;
    logic       bus_select_hi;
    logic       reset_n;
    logic       cs_n;
    logic       dc;
    logic       strobe;
    logic       dir;
    logic [7:0] bus_h_out;
    logic       bus_h_oe;
    logic [7:0] bus_d_out;
    logic       bus_d_oe;
    logic [7:0] host_bus;
    logic       frame_status_out;

    assign host_bus = bus_h_oe ? bus_h_out : (bus_d_oe ? bus_d_out : oled_if_pkg::BUS_IDLE);

    modport host (output bus_select_lo, bus_select_hi, reset_n, cs_n, dc, strobe, dir,
                  output bus_h_out, bus_h_oe, input host_bus);
    modport dev (input bus_select_lo, bus_select_hi, reset_n, cs_n, dc, strobe, dir,
                 input host_bus, output bus_d_out, bus_d_oe, frame_status_out);
endinterface

`default_nettype wire

// ---- skid_buf2.sv ----
// two-entry buffer with valid/ready on both sides
// assumes a synchronous active-low reset on the same clock
`default_nettype none

module skid_buf2 #(
    parameter int W = 9
) (
    input  wire logic         clk,       // system clock
    input  wire logic         nrst,      // sync reset, low active
    input  wire logic         ce,        // clock enable
    input  wire logic         in_valid,  // word offered
    output logic              in_ready,  // room for a word
    input  wire logic [W-1:0] in_data,   // word in
    output logic              out_valid, // word available
    input  wire logic         out_ready, // drain side takes
    output logic [W-1:0]      out_data   // word out
);
    logic         out_v_ff, nxt_out_v, skid_v_ff, nxt_skid_v;
    logic [W-1:0] out_d_ff, nxt_out_d, skid_d_ff, nxt_skid_d;
    logic         push;

    always_comb begin
        push       = in_valid && !skid_v_ff;
        nxt_out_v  = out_v_ff;
        nxt_out_d  = out_d_ff;
        nxt_skid_v = skid_v_ff;
        nxt_skid_d = skid_d_ff;
        if (!out_v_ff || out_ready) begin
            if (skid_v_ff) begin
                nxt_out_v  = 1'b1;
                nxt_out_d  = skid_d_ff;
                nxt_skid_v = 1'b0;
            end else begin
                nxt_out_v = push;
                if (push) begin
                    nxt_out_d = in_data;
                end
            end
        end else if (push) begin
            nxt_skid_v = 1'b1;
            nxt_skid_d = in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_v_ff  <= 1'b0;
            skid_v_ff <= 1'b0;
            out_d_ff  <= '0;
            skid_d_ff <= '0;
        end else if (ce) begin
            out_v_ff  <= nxt_out_v;
            skid_v_ff <= nxt_skid_v;
            out_d_ff  <= nxt_out_d;
            skid_d_ff <= nxt_skid_d;
        end
    end

    assign in_ready  = !skid_v_ff;
    assign out_valid = out_v_ff;
    assign out_data  = out_d_ff;
endmodule // skid_buf2

`default_nettype wire

// ---- oled_dev_end.sv ----
// display-module end of the host port: samples the pins, decodes the bus
// mode, collects written bytes into a buffer and answers reads
// assumes all pins are asynchronous to ref_clk
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module oled_dev_end
    import oled_if_pkg::*;
#(
    parameter int FRAME_HALF_CYC = FRAME_HALF_DEF,
    parameter int COL_W          = 7
) (
    input  wire logic             ref_clk,        // system clock
    input  wire logic             nrst,           // sync reset, low active
    input  wire logic             ce,             // clock enable
    oled_if.dev                   pins,           // host pins
    output logic                  wr_valid,       // received byte valid
    input  wire logic             wr_ready,       // user takes byte
    output logic [7:0]            wr_data,        // received byte
    output logic                  wr_is_data,     // byte is display data
    input  wire logic [7:0]       rd_data,        // byte for host reads
    output logic                  rd_take,        // read served pulse
    input  wire logic             cfg_we,         // load settings
    input  wire logic             cfg_display_on, // display on
    input  wire logic [7:0]       cfg_contrast,   // contrast
    input  wire logic [6:0]       cfg_start_line, // start line
    input  wire logic [1:0]       cfg_map,        // remap and scan
    output logic                  display_on,     // display on
    output logic [7:0]            contrast,       // contrast
    output logic [6:0]            start_line,     // start line
    output logic [1:0]            map_scan,       // remap and scan
    output logic [COL_W-1:0]      col_addr,       // column counter
    output mode_t                 bus_mode        // decoded mode
);
    localparam int FW = $clog2(FRAME_HALF_CYC + 1);

    pin_s_t meta_ff, sync_ff, pin_now;
    logic   core_rst;

    always_comb begin
        pin_now = '{cs_n: pins.cs_n, dc: pins.dc, strobe: pins.strobe, dir: pins.dir,
                    bus: pins.host_bus, bs_lo: pins.bus_select_lo,
                    bs_hi: pins.bus_select_hi, rst_n: pins.reset_n};
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce) begin
            meta_ff <= pin_now;
            sync_ff <= meta_ff;
        end
    end

    assign core_rst = !nrst || !sync_ff.rst_n;

    //////////////////////////////////////////////////////////////////////////////
    logic              wact_ff, nxt_wact, ract_ff, nxt_ract, sck_ff, nxt_sck;
    logic [7:0]        lat_ff, nxt_lat, dout_ff, nxt_dout;
    logic              dcl_ff, nxt_dcl, drv_ff, nxt_drv, take_ff, nxt_take;
    logic [8:0]        sh_ff, nxt_sh, pend_d_ff, nxt_pend_d;
    logic [BIT_W-1:0]  bit_ff, nxt_bit;
    logic              pend_v_ff, nxt_pend_v;
    logic [COL_W-1:0]  col_ff, nxt_col;
    logic [FW-1:0]     fcnt_ff, nxt_fcnt;
    logic              frame_ff, nxt_frame;
    logic              disp_ff, nxt_disp;
    logic [7:0]        con_ff, nxt_con;
    logic [6:0]        start_ff, nxt_start;
    logic [1:0]        map_ff, nxt_map;
    mode_t             mode_ff, mode;
    logic              par, sel, wr_act, rd_act, sck_rise, push, buf_ready;
    logic [8:0]        push_d, full;
    logic [3:0]        flen;

    always_comb begin
        mode     = decode_mode(sync_ff.bs_lo, sync_ff.bs_hi);
        par      = (mode == M_68) || (mode == M_80);
        sel      = !sync_ff.cs_n;
        wr_act   = sel && par && ((mode == M_68) ? (sync_ff.strobe && !sync_ff.dir) : !sync_ff.dir);
        rd_act   = sel && par && ((mode == M_68) ? (sync_ff.strobe && sync_ff.dir) : !sync_ff.strobe);
        sck_rise = sel && !par && sync_ff.bus[SCK_BIT] && !sck_ff;
        flen     = (mode == M_SPI3) ? SPI3_BITS : SPI4_BITS;
        full     = {sh_ff[7:0], sync_ff.bus[SDI_BIT]};
        push     = 1'b0;
        push_d   = pend_d_ff;
        nxt_wact = wr_act;
        nxt_ract = rd_act;
        nxt_sck  = sync_ff.bus[SCK_BIT];
        nxt_lat  = lat_ff;
        nxt_dcl  = dcl_ff;
        nxt_sh   = sh_ff;
        nxt_bit  = bit_ff;
        if (wr_act) begin
            nxt_lat = sync_ff.bus;
            nxt_dcl = sync_ff.dc;
        end
        if (wact_ff && !wr_act) begin
            push   = 1'b1;
            push_d = {dcl_ff, lat_ff};
        end
        if (!sel || par) begin
            nxt_bit = '0;
        end else if (sck_rise) begin
            nxt_sh  = full;
            nxt_bit = bit_ff + 1'b1;
            if (bit_ff + 1'b1 == flen) begin
                nxt_bit = '0;
                push    = 1'b1;
                push_d  = {(mode == M_SPI3) ? full[8] : sync_ff.dc, full[7:0]};
            end
        end
        // new capture wins over the drain clear
        nxt_pend_v = (pend_v_ff && !buf_ready) || push;
        nxt_pend_d = push ? push_d : pend_d_ff;
        nxt_col    = (push && push_d[8]) ? col_ff + 1'b1 : col_ff;
        nxt_take   = rd_act && !ract_ff;
        nxt_drv    = rd_act;
        nxt_dout   = nxt_take ? rd_data : dout_ff;
        nxt_fcnt   = fcnt_ff + 1'b1;
        nxt_frame  = frame_ff;
        if (fcnt_ff == FW'(FRAME_HALF_CYC - 1)) begin
            nxt_fcnt  = '0;
            nxt_frame = !frame_ff;
        end
        nxt_disp  = cfg_we ? cfg_display_on : disp_ff;
        nxt_con   = cfg_we ? cfg_contrast : con_ff;
        nxt_start = cfg_we ? cfg_start_line : start_ff;
        nxt_map   = cfg_we ? cfg_map : map_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            wact_ff   <= 1'b0;
            ract_ff   <= 1'b0;
            sck_ff    <= 1'b0;
            lat_ff    <= '0;
            dcl_ff    <= 1'b0;
            sh_ff     <= '0;
            bit_ff    <= '0;
            pend_v_ff <= 1'b0;
            pend_d_ff <= '0;
            take_ff   <= 1'b0;
            drv_ff    <= 1'b0;
            dout_ff   <= '0;
            fcnt_ff   <= '0;
            frame_ff  <= 1'b0;
            mode_ff   <= M_SPI4;
            disp_ff   <= 1'b0;
            con_ff    <= CONTRAST_RST;
            start_ff  <= START_RST;
            map_ff    <= '0;
            col_ff    <= '0;
        end else if (ce) begin
            wact_ff   <= nxt_wact;
            ract_ff   <= nxt_ract;
            sck_ff    <= nxt_sck;
            lat_ff    <= nxt_lat;
            dcl_ff    <= nxt_dcl;
            sh_ff     <= nxt_sh;
            bit_ff    <= nxt_bit;
            pend_v_ff <= nxt_pend_v;
            pend_d_ff <= nxt_pend_d;
            take_ff   <= nxt_take;
            drv_ff    <= nxt_drv;
            dout_ff   <= nxt_dout;
            fcnt_ff   <= nxt_fcnt;
            frame_ff  <= nxt_frame;
            mode_ff   <= mode;
            disp_ff   <= nxt_disp;
            con_ff    <= nxt_con;
            start_ff  <= nxt_start;
            map_ff    <= nxt_map;
            col_ff    <= nxt_col;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    logic [8:0] wr_word;

    skid_buf2 #(.W(9)) u_buf (
        .clk       (ref_clk),
        .nrst      (!core_rst),
        .ce        (ce),
        .in_valid  (pend_v_ff),
        .in_ready  (buf_ready),
        .in_data   (pend_d_ff),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_word)
    );

    assign wr_data               = wr_word[7:0];
    assign wr_is_data            = wr_word[8];
    assign rd_take               = take_ff;
    assign display_on            = disp_ff;
    assign contrast              = con_ff;
    assign start_line            = start_ff;
    assign map_scan              = map_ff;
    assign col_addr              = col_ff;
    assign bus_mode              = mode_ff;
    assign pins.bus_d_out        = dout_ff;
    assign pins.bus_d_oe         = drv_ff;
    assign pins.frame_status_out = frame_ff;
endmodule // oled_dev_end

`default_nettype wire

// ---- oled_host_end.sv ----
// host-controller end: turns byte requests into 68, 80 or serial bus cycles
// assumes the device end samples the pins on its own clock
`default_nettype none

module oled_host_end
    import oled_if_pkg::*;
(
    input  wire logic       ref_clk,     // system clock
    input  wire logic       nrst,        // sync reset, low active
    input  wire logic       ce,          // clock enable
    oled_if.host            pins,        // display pins
    input  wire logic [1:0] strap_sel,   // {hi, lo} strap levels
    input  wire logic       dev_rst_req, // hold device reset
    input  wire logic       req_valid,   // request offered
    output logic            req_ready,   // request taken when high
    input  wire logic       req_read,    // 1 read, 0 write
    input  wire logic       req_dc,      // 1 data, 0 command
    input  wire logic [7:0] req_data,    // write byte
    output logic            rsp_valid,   // read byte pulse
    output logic [7:0]      rsp_data     // read byte
);
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_ACT, H_HOLD, H_SLO, H_SHI, H_GAP} hst_t;

    hst_t             st_ff, nxt_st;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [BIT_W-1:0] bits_ff, nxt_bits;
    logic [8:0]       sh_ff, nxt_sh;
    logic [7:0]       dout_ff, nxt_dout, rsp_d_ff, nxt_rsp_d, bm_ff, bs_ff;
    logic             cs_n_ff, nxt_cs_n, dc_ff, nxt_dc, stb_ff, nxt_stb, dir_ff, nxt_dir;
    logic             oe_ff, nxt_oe, rd_ff, nxt_rd, rsp_v_ff, nxt_rsp_v, rdy_ff, nxt_rdy;
    logic             rst_n_ff, lo_ff, hi_ff;
    mode_t            mode;
    logic             par, stb_idle, dir_idle, done;

    always_comb begin
        mode      = decode_mode(lo_ff, hi_ff);
        par       = (mode == M_68) || (mode == M_80);
        stb_idle  = (mode == M_80);
        dir_idle  = (mode == M_80);
        done      = (cnt_ff == '0);
        nxt_st    = st_ff;
        nxt_cnt   = done ? cnt_ff : cnt_ff - 1'b1;
        nxt_bits  = bits_ff;
        nxt_sh    = sh_ff;
        nxt_dout  = dout_ff;
        nxt_cs_n  = cs_n_ff;
        nxt_dc    = dc_ff;
        nxt_stb   = stb_ff;
        nxt_dir   = dir_ff;
        nxt_oe    = oe_ff;
        nxt_rd    = rd_ff;
        nxt_rsp_v = 1'b0;
        nxt_rsp_d = rsp_d_ff;
        unique case (st_ff)
            H_IDLE: begin
                nxt_cs_n = 1'b1;
                nxt_stb  = stb_idle;
                nxt_dir  = dir_idle;
                nxt_oe   = !par;
                nxt_dout = '0;
                // reads have no serial path and are dropped
                if (req_valid && rdy_ff && !(req_read && !par)) begin
                    nxt_st   = H_SETUP;
                    nxt_cnt  = SETUP_CYC - 1'b1;
                    nxt_cs_n = 1'b0;
                    nxt_rd   = req_read && par;
                    nxt_dc   = (mode == M_SPI3) ? 1'b0 : req_dc;
                    nxt_dir  = (mode == M_68) ? req_read : dir_idle;
                    nxt_oe   = !(req_read && par);
                    nxt_dout = par ? req_data : '0;
                    nxt_sh   = (mode == M_SPI3) ? {req_dc, req_data} : {req_data, 1'b0};
                    nxt_bits = (mode == M_SPI3) ? SPI3_BITS : SPI4_BITS;
                end
            end
            H_SETUP: begin
                if (done) begin
                    nxt_st  = par ? H_ACT : H_SLO;
                    nxt_cnt = par ? ACT_CYC - 1'b1 : HALF_CYC - 1'b1;
                    if (mode == M_68) begin
                        nxt_stb = 1'b1;
                    end else if (mode == M_80) begin
                        nxt_stb = !rd_ff;
                        nxt_dir = rd_ff;
                    end
                    if (!par) begin
                        nxt_dout[SDI_BIT] = sh_ff[8];
                    end
                end
            end
            H_ACT: begin
                if (done) begin
                    nxt_st  = H_HOLD;
                    nxt_cnt = HOLD_CYC - 1'b1;
                    nxt_stb = stb_idle;
                    nxt_dir = (mode == M_68) ? dir_ff : dir_idle;
                    if (rd_ff) begin
                        nxt_rsp_v = 1'b1;
                        nxt_rsp_d = bs_ff;
                    end
                end
            end
            H_SLO: begin
                if (done) begin
                    nxt_st            = H_SHI;
                    nxt_cnt           = HALF_CYC - 1'b1;
                    nxt_dout[SCK_BIT] = 1'b1;
                end
            end
            H_SHI: begin
                if (done) begin
                    nxt_dout[SCK_BIT] = 1'b0;
                    nxt_bits          = bits_ff - 1'b1;
                    nxt_sh            = {sh_ff[7:0], 1'b0};
                    nxt_dout[SDI_BIT] = sh_ff[7];
                    nxt_st            = (bits_ff == 4'h1) ? H_HOLD : H_SLO;
                    nxt_cnt           = (bits_ff == 4'h1) ? HOLD_CYC - 1'b1 : HALF_CYC - 1'b1;
                end
            end
            H_HOLD: begin
                if (done) begin
                    nxt_st   = H_GAP;
                    nxt_cnt  = GAP_CYC - 1'b1;
                    nxt_cs_n = 1'b1;
                    nxt_oe   = !par;
                end
            end
            H_GAP: begin
                if (done) begin
                    nxt_st = H_IDLE;
                end
            end
        endcase
        nxt_rdy = (nxt_st == H_IDLE) && !(st_ff == H_IDLE && req_valid && rdy_ff && !(req_read && !par));
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_ff    <= H_IDLE;
            cnt_ff   <= '0;
            bits_ff  <= '0;
            sh_ff    <= '0;
            dout_ff  <= '0;
            cs_n_ff  <= 1'b1;
            dc_ff    <= 1'b0;
            stb_ff   <= 1'b0;
            dir_ff   <= 1'b0;
            oe_ff    <= 1'b0;
            rd_ff    <= 1'b0;
            rsp_v_ff <= 1'b0;
            rsp_d_ff <= '0;
            rdy_ff   <= 1'b0;
            rst_n_ff <= 1'b0;
            lo_ff    <= 1'b0;
            hi_ff    <= 1'b0;
            bm_ff    <= '0;
            bs_ff    <= '0;
        end else if (ce) begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            bits_ff  <= nxt_bits;
            sh_ff    <= nxt_sh;
            dout_ff  <= nxt_dout;
            cs_n_ff  <= nxt_cs_n;
            dc_ff    <= nxt_dc;
            stb_ff   <= nxt_stb;
            dir_ff   <= nxt_dir;
            oe_ff    <= nxt_oe;
            rd_ff    <= nxt_rd;
            rsp_v_ff <= nxt_rsp_v;
            rsp_d_ff <= nxt_rsp_d;
            rdy_ff   <= nxt_rdy;
            rst_n_ff <= !dev_rst_req;
            lo_ff    <= strap_sel[0];
            hi_ff    <= strap_sel[1];
            bm_ff    <= pins.host_bus;
            bs_ff    <= bm_ff;
        end
    end

    assign pins.bus_select_lo = lo_ff;
    assign pins.bus_select_hi = hi_ff;
    assign pins.reset_n       = rst_n_ff;
    assign pins.cs_n          = cs_n_ff;
    assign pins.dc            = dc_ff;
    assign pins.strobe        = stb_ff;
    assign pins.dir           = dir_ff;
    assign pins.bus_h_out     = dout_ff;
    assign pins.bus_h_oe      = oe_ff;
    assign req_ready          = rdy_ff;
    assign rsp_valid          = rsp_v_ff;
    assign rsp_data           = rsp_d_ff;
endmodule // oled_host_end

`default_nettype wire

// ---- oled_pin_checker.sv ----
// pin assertions between host end and device end
// assumes plain copies of the link signals as inputs
`default_nettype none
module oled_pin_checker (
    input wire logic       ref_clk,          // clock
    input wire logic       nrst,             // reset
    input wire logic       bus_select_lo,    // strap
    input wire logic       bus_select_hi,    // strap
    input wire logic       cs_n,             // select
    input wire logic       strobe,           // e or rd_n
    input wire logic       dir,              // r/w or wr_n
    input wire logic       bus_h_oe,         // host drives
    input wire logic       bus_d_oe,         // device drives
    input wire logic [7:0] host_bus,         // bus
    input wire logic       frame_status_out  // frame
);
    timeunit 1ns;
    timeprecision 1ps;
    wire m68 = bus_select_hi & bus_select_lo;
    wire m80 = bus_select_hi & ~bus_select_lo;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    property p_clash; !(bus_h_oe && bus_d_oe); endproperty
    a_clash: assert property (p_clash) else $error("bus clash");
    property p_rdsel; $rose(bus_d_oe) |-> !cs_n; endproperty
    a_rdsel: assert property (p_rdsel) else $error("read unselected");
    property p_rd68; $rose(bus_d_oe) && m68 |-> strobe && dir; endproperty
    a_rd68: assert property (p_rd68) else $error("68 read pins");
    property p_rd80; $rose(bus_d_oe) && m80 |-> !strobe && dir; endproperty
    a_rd80: assert property (p_rd80) else $error("80 read pins");
    property p_wr80; m80 && $fell(dir) |-> !cs_n && bus_h_oe; endproperty
    a_wr80: assert property (p_wr80) else $error("80 write pins");
    property p_ser; !bus_select_hi |-> !strobe && !dir && !bus_d_oe; endproperty
    a_ser: assert property (p_ser) else $error("serial pins");
    property p_sdi; !bus_select_hi && !cs_n && $rose(host_bus[0]) |-> $stable(host_bus[1]); endproperty
    a_sdi: assert property (p_sdi) else $error("data moved at clock");
    property p_frm; $changed(frame_status_out) |=>
        $stable(frame_status_out) [*8] ##[1:10] $changed(frame_status_out); endproperty
    a_frm: assert property (p_frm) else $error("frame rate");
endmodule // oled_pin_checker
`default_nettype wire

// ---- tb_top.sv ----
// bench: host end drives device end in all four bus modes
// assumes both ends share ref_clk and nrst
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import oled_if_pkg::*;
    logic       ref_clk, nrst, dev_rst_req, req_valid, req_ready, req_read, req_dc, rsp_valid;
    logic       wr_valid, wr_ready, wr_is_data, cfg_we, cfg_on, display_on, rd_take;
    logic [1:0] strap_sel, map_scan;
    logic [6:0] col_addr, start_line;
    logic [7:0] req_data, rsp_data, wr_data, rd_data, contrast;
    mode_t      bus_mode;
    int         mismatches, checks_done, n, takes;
    oled_if link ();
    oled_host_end oled_host_end_i (.ref_clk, .nrst, .ce(1'b1), .pins(link), .strap_sel, .dev_rst_req,
        .req_valid, .req_ready, .req_read, .req_dc, .req_data, .rsp_valid, .rsp_data);
    oled_dev_end #(.FRAME_HALF_CYC(16)) oled_dev_end_i (.ref_clk, .nrst, .ce(1'b1), .pins(link), .wr_valid,
        .wr_ready, .wr_data, .wr_is_data, .rd_data, .rd_take, .cfg_we, .cfg_display_on(cfg_on),
        .cfg_contrast(rd_data), .cfg_start_line(7'h05), .cfg_map(2'h2), .display_on, .contrast,
        .start_line, .map_scan, .col_addr, .bus_mode);
    oled_pin_checker oled_pin_checker_i (.ref_clk, .nrst, .bus_select_lo(link.bus_select_lo),
        .bus_select_hi(link.bus_select_hi), .cs_n(link.cs_n), .strobe(link.strobe), .dir(link.dir),
        .bus_h_oe(link.bus_h_oe), .bus_d_oe(link.bus_d_oe), .host_bus(link.host_bus),
        .frame_status_out(link.frame_status_out));
    // counts read-start pulses over the whole run
    always @(posedge ref_clk) begin
        if (rd_take === 1'b1) takes++;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic cmp9(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one request, held until taken; reads wait for the answer
    task automatic req(input logic rd, input logic dc, input logic [7:0] d);
        {req_valid, req_read, req_dc, req_data} = {1'b1, rd, dc, d};
        for (n = 0; req_ready !== 1'b1 && n < 400; n++) tick(1);
        if (n == 400) mismatches++;
        tick(1);
        req_valid = 1'b0;
        tick(2);
        for (n = 0; rd && rsp_valid !== 1'b1 && n < 40; n++) tick(1);
        if (rd && n == 40) mismatches++;
        if (rd) cmp9({1'b0, rsp_data}, {1'b0, rd_data});
    endtask
    task automatic pull(input logic dc, input logic [7:0] d);
        for (n = 0; wr_valid !== 1'b1 && n < 400; n++) tick(1);
        if (n == 400) mismatches++;
        cmp9({wr_is_data, wr_data}, {dc, d});
        wr_ready = 1'b1;
        tick(1);
        wr_ready = 1'b0;
        tick(1);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        tick(20000);
        mismatches++;
        report_and_stop();
    end
    initial begin
        {req_valid, req_read, req_dc, wr_ready, cfg_we, cfg_on, req_data, rd_data} = '0;
        mismatches = 0;
        checks_done = 0;
        takes = 0;
        for (int s = 0; s < 4; s++) begin
            {nrst, dev_rst_req, strap_sel} = {2'b01, 2'(s)};
            tick(5);
            {nrst, dev_rst_req} = 2'b10;
            tick(12);
            cmp9({7'h0, bus_mode}, 9'(s));
            cmp9({display_on, contrast}, 9'h07F);
            cmp9({2'h0, col_addr}, 9'h000);
            cmp9({map_scan, start_line}, 9'h000);
            // receiver stalls while both words queue
            req(1'b0, 1'b0, 8'hA5);
            req(1'b0, 1'b1, 8'h3C);
            pull(1'b0, 8'hA5);
            pull(1'b1, 8'h3C);
            cmp9({2'h0, col_addr}, 9'h001);
            rd_data = 8'h96;
            if (s > 1) req(1'b1, 1'b0, 8'h00);
            if (s > 1) cmp9(9'(takes), 9'(s - 1));
            {cfg_we, cfg_on} = {1'b1, s[0]};
            tick(1);
            cfg_we = 1'b0;
            tick(1);
            cmp9({display_on, contrast}, {s[0], 8'h96});
            cmp9({map_scan, start_line}, 9'h105);
        end
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
